// ==== hw/t16_pkg.sv ====
// Constants shared by the 16-bit timer control block
package t16_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_TWO = 4'h1;  // Control two
  localparam logic [3:0] IDX_CTRL_ONE = 4'h2;  // Control one
  localparam logic [3:0] IDX_FLAGS    = 4'h3;  // Flags and freeze
  localparam logic [3:0] IDX_CAP1_HI  = 4'h4;  // Capture one high
  localparam logic [3:0] IDX_CAP1_LO  = 4'h5;  // Capture one low
  localparam logic [3:0] IDX_CMP1_HI  = 4'h6;  // Compare one high
  localparam logic [3:0] IDX_CMP1_LO  = 4'h7;  // Compare one low
  localparam logic [3:0] IDX_CMP2_HI  = 4'h8;  // Compare two high
  localparam logic [3:0] IDX_CMP2_LO  = 4'h9;  // Compare two low
  localparam logic [3:0] IDX_CNT_HI   = 4'hA;  // Counter high
  localparam logic [3:0] IDX_CNT_LO   = 4'hB;  // Counter low
  localparam logic [3:0] IDX_ACNT_HI  = 4'hC;  // Alternate counter high
  localparam logic [3:0] IDX_ACNT_LO  = 4'hD;  // Alternate counter low
  localparam logic [3:0] IDX_CAP2_HI  = 4'hE;  // Capture two high
  localparam logic [3:0] IDX_CAP2_LO  = 4'hF;  // Capture two low
  // ----------------------------------------------------------------
  // Control one bit positions
  // ----------------------------------------------------------------
  localparam int C1_CAP_IE  = 7;  // capture_irq_enable
  localparam int C1_CMP_IE  = 6;  // compare_irq_enable
  localparam int C1_OVF_IE  = 5;  // overflow_irq_enable
  localparam int C1_FORCE2  = 4;  // force_compare_two
  localparam int C1_FORCE1  = 3;  // force_compare_one
  localparam int C1_LEVEL2  = 2;  // level_two
  localparam int C1_EDGE1   = 1;  // edge_select_one
  localparam int C1_LEVEL1  = 0;  // level_one
  // ----------------------------------------------------------------
  // Control two bit positions
  // ----------------------------------------------------------------
  localparam int C2_PIN1_EN = 7;  // pin_one_enable
  localparam int C2_PIN2_EN = 6;  // pin_two_enable
  localparam int C2_SPM     = 5;  // single_pulse_mode
  localparam int C2_PWM     = 4;  // pulse-width mode
  localparam int C2_CLK_HI  = 3;  // clock_select msb
  localparam int C2_CLK_LO  = 2;  // clock_select lsb
  localparam int C2_EDGE2   = 1;  // edge_select_two
  localparam int C2_EXT_EDG = 0;  // ext_clock_edge
  // ----------------------------------------------------------------
  // Flag register bit positions
  // ----------------------------------------------------------------
  localparam int FL_CAP1 = 7;  // capture_flag_one
  localparam int FL_CMP1 = 6;  // match_flag_one
  localparam int FL_OVF  = 5;  // overflow_flag
  localparam int FL_CAP2 = 4;  // capture_flag_two
  localparam int FL_CMP2 = 3;  // match_flag_two
  localparam int FL_FRZ  = 2;  // timer_freeze
  // ----------------------------------------------------------------
  // Reset values and clock codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST  = 8'h00;    // Control reset value
  localparam logic [15:0] CNT_RST   = 16'hFFFC; // Counter start value
  localparam logic [15:0] CNT_TOP   = 16'hFFFF; // Last count before roll
  localparam logic [1:0]  CLK_DIV4  = 2'h0;     // CPU clock / 4
  localparam logic [1:0]  CLK_DIV2  = 2'h1;     // CPU clock / 2
  localparam logic [1:0]  CLK_DIV8  = 2'h2;     // CPU clock / 8
  localparam logic [1:0]  CLK_EXT   = 2'h3;     // External clock
  localparam logic [2:0]  PRE_LAST4 = 3'h3;     // Last prescaler count /4
  localparam logic [2:0]  PRE_LAST2 = 3'h1;     // Last prescaler count /2
  localparam logic [2:0]  PRE_LAST8 = 3'h7;     // Last prescaler count /8
endpackage : t16_pkg

// ==== hw/t16_edge.sv ====
// Edge detector with selectable polarity for timer pins
`timescale 1ns/10ps
module t16_edge (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  // Pin and polarity
  input  wire logic i_pin,
  input  wire logic i_rise_sel,
  // Detected edge
  output logic      o_hit
);
  logic pin_q;   // Pin level one cycle ago
  logic seen_q;  // One sample taken since reset

  // ----------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      pin_q  <= i_pin;
      seen_q <= 1'b1;
    end
  end

  // Rising when selected, falling otherwise; no false edge after reset
  assign o_hit = seen_q & (i_rise_sel ? (i_pin & ~pin_q) : (~i_pin & pin_q));
endmodule : t16_edge

// ==== hw/t16_ctrl_regs.sv ====
// 16-bit timer with captures, compares, pulse modes and APB registers
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// Function
// - Capture enable gates capture flags onto interrupt
// - Compare enable gates match flags onto interrupt
// - Overflow enable gates overflow flag onto interrupt
// - Force two copies level two to pin
// - Force one copies level one to pin
// - Match two drives level two
// - Pulse modes also drive level two on one
// - Edge select one picks capture one polarity
// - Match one drives level one
// - Pin one enable routes only, compare runs
// - Pin one carries one or both levels
// - Pin two enable routes only, compare runs
// - Single pulse triggered by capture one edge
// - Compare one sets single pulse length
// - Pulse-width: compare one length, two period
// - Clock select: div4, div2, div8, external
// - External code without pin stops counter
// - Edge select two picks capture two polarity
// - External edge bit picks counting transition
// - Three control registers, six data pairs
// - Control two resets zero, fully writable
// - Freeze stops counting, outputs; registers usable
// - Both modes set means pulse-width only
// - Period end sets capture flag, reloads FFFC
module t16_ctrl_regs
  import t16_pkg::*;
#(
  parameter int  ADDR_W  = 8,    // APB address width
  parameter bit  EXT_PIN = 1'b1  // External clock pin present
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Timer pins
  input  wire logic              i_capture_in_one,
  input  wire logic              i_capture_in_two,
  input  wire logic              i_ext_count_clock,
  output logic                   o_compare_out_one,
  output logic                   o_compare_one_oe_n,
  output logic                   o_compare_out_two,
  output logic                   o_compare_two_oe_n,
  // Shared interrupt
  output logic                   o_timer_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_q;           // Control one
  logic [7:0]  ctrl_two_q;           // Control two
  logic        freeze_q;             // Timer freeze
  logic        cap1_f_q, cap2_f_q;   // Capture flags
  logic        cmp1_f_q, cmp2_f_q;   // Match flags
  logic        ovf_f_q;              // Overflow flag
  logic [4:0]  armed_q;              // Flags seen by a flag read
  logic [15:0] cnt_q;                // Free-running counter
  logic [2:0]  pre_q;                // Prescaler
  logic [15:0] cap1_q, cap2_q;       // Captured values
  logic [15:0] cmp1_q, cmp2_q;       // Compare values
  logic        inh1_q, inh2_q;       // Compare held off after high write
  logic        out1_q, out2_q;       // Compare pin levels
  logic [31:0] rd_d;                 // Read data next
  logic [2:0]  hit;                  // Edge hits: cap1, cap2, ext

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  logic [3:0] idx;       // Register index
  logic       mapped;    // Address hits a register
  logic       acc;       // Access completes this edge
  logic       wr, rd;    // Completing write or read
  assign idx    = i_paddr[5:2];
  assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:6] == '0)
                  && (idx != 4'h0);
  assign acc    = i_psel & i_penable & o_pready;
  assign wr     = acc & i_pwrite & mapped;
  assign rd     = acc & ~i_pwrite & mapped;

  // Last prescaler count for a clock code
  function automatic logic [2:0] pre_last(input logic [1:0] sel);
    unique case (sel)
      CLK_DIV2: pre_last = PRE_LAST2;
      CLK_DIV8: pre_last = PRE_LAST8;
      default:  pre_last = PRE_LAST4;
    endcase
  endfunction : pre_last

  // Either access to a register index
  function automatic logic hit_idx(input logic [3:0] i, input logic a);
    hit_idx = a && (idx == i);
  endfunction : hit_idx

  // ----------------------------------------------------------------
  // Modes and events
  // ----------------------------------------------------------------
  logic pwm_on, spm_on;     // Active mode
  logic [1:0] clk_sel;      // Clock select field
  logic tick;               // Counter advances
  logic cap1, cap2;         // Capture events
  logic m1, m2;             // Compare matches
  logic cnt_wr;             // Counter reset by software
  assign pwm_on  = ctrl_two_q[C2_PWM];
  assign spm_on  = ctrl_two_q[C2_SPM] & ~pwm_on;
  assign clk_sel = ctrl_two_q[C2_CLK_HI:C2_CLK_LO];
  assign cap1    = hit[0] & ~pwm_on;
  assign cap2    = hit[1];
  assign cnt_wr  = hit_idx(IDX_CNT_LO, wr) | hit_idx(IDX_ACNT_LO, wr);

  // Counter tick from prescaler or external pin
  always_comb begin
    if (freeze_q) begin
      tick = 1'b0;
    end else if (clk_sel == CLK_EXT) begin
      tick = EXT_PIN & hit[2];
    end else begin
      tick = (pre_q == pre_last(clk_sel));
    end
  end

  // Matches count whatever the pin enables say
  assign m1 = tick & ~inh1_q & (cnt_q == cmp1_q);
  assign m2 = tick & ~inh2_q & (cnt_q == cmp2_q);

  // ----------------------------------------------------------------
  // Pin edge detectors
  // ----------------------------------------------------------------
  logic [2:0] pins, pols;  // Pin levels and rising selects
  assign pins = {i_ext_count_clock, i_capture_in_two, i_capture_in_one};
  assign pols = {ctrl_two_q[C2_EXT_EDG], ctrl_two_q[C2_EDGE2],
                 ctrl_one_q[C1_EDGE1]};
  for (genvar g = 0; g < 3; g++) begin : g_edge
    t16_edge u_edge (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_pin     (pins[g]),
      .i_rise_sel(pols[g]),
      .o_hit     (hit[g])
    );
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_one_q <= CTRL_RST;
      ctrl_two_q <= CTRL_RST;
      freeze_q   <= 1'b0;
    end else begin
      if (hit_idx(IDX_CTRL_ONE, wr)) begin
        ctrl_one_q <= i_pwdata[7:0];
      end
      if (hit_idx(IDX_CTRL_TWO, wr)) begin
        ctrl_two_q <= i_pwdata[7:0];
      end
      if (hit_idx(IDX_FLAGS, wr)) begin
        freeze_q <= i_pwdata[FL_FRZ];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_q <= 3'h0;
      cnt_q <= CNT_RST;
    end else if (cnt_wr) begin
      pre_q <= 3'h0;
      cnt_q <= CNT_RST;
    end else begin
      if (!freeze_q) begin
        pre_q <= tick ? 3'h0 : pre_q + 3'h1;
      end
      if (spm_on && cap1) begin
        cnt_q <= CNT_RST;
      end else if (pwm_on && m2) begin
        cnt_q <= CNT_RST;
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture and compare data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
      cmp1_q <= 16'h0000;
      cmp2_q <= 16'h0000;
      inh1_q <= 1'b0;
      inh2_q <= 1'b0;
    end else begin
      if (cap1) begin
        cap1_q <= cnt_q;
      end
      if (cap2) begin
        cap2_q <= cnt_q;
      end
      // High write holds compare off until low write
      if (hit_idx(IDX_CMP1_HI, wr)) begin
        cmp1_q[15:8] <= i_pwdata[7:0];
        inh1_q       <= 1'b1;
      end else if (hit_idx(IDX_CMP1_LO, wr)) begin
        cmp1_q[7:0] <= i_pwdata[7:0];
        inh1_q      <= 1'b0;
      end
      if (hit_idx(IDX_CMP2_HI, wr)) begin
        cmp2_q[15:8] <= i_pwdata[7:0];
        inh2_q       <= 1'b1;
      end else if (hit_idx(IDX_CMP2_LO, wr)) begin
        cmp2_q[7:0] <= i_pwdata[7:0];
        inh2_q      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags: set beats clear; clear needs a prior flag read
  // ----------------------------------------------------------------
  logic [4:0] flags, set_f, clr_f;  // cap1, cmp1, ovf, cap2, cmp2
  assign flags = {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q};
  assign set_f = {cap1 | (pwm_on & m2),
                  m1 & ~pwm_on,
                  tick & (cnt_q == CNT_TOP),
                  cap2,
                  m2 & ~pwm_on};
  assign clr_f = armed_q & {hit_idx(IDX_CAP1_LO, acc & mapped),
                            hit_idx(IDX_CMP1_LO, acc & mapped),
                            hit_idx(IDX_CNT_LO,  acc & mapped),
                            hit_idx(IDX_CAP2_LO, acc & mapped),
                            hit_idx(IDX_CMP2_LO, acc & mapped)};
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q} <= 5'h00;
      armed_q <= 5'h00;
    end else begin
      {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q} <= set_f | (flags & ~clr_f);
      if (hit_idx(IDX_FLAGS, rd)) begin
        armed_q <= flags;
      end else begin
        armed_q <= armed_q & ~clr_f;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare pin levels
  // ----------------------------------------------------------------
  logic frc1, frc2;  // Force strobes from a control one write
  assign frc1 = hit_idx(IDX_CTRL_ONE, wr) & i_pwdata[C1_FORCE1];
  assign frc2 = hit_idx(IDX_CTRL_ONE, wr) & i_pwdata[C1_FORCE2];
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      if (frc1) begin
        out1_q <= i_pwdata[C1_LEVEL1];
      end else if ((spm_on && cap1) || (pwm_on && m2)) begin
        out1_q <= ctrl_one_q[C1_LEVEL2];
      end else if (m1) begin
        out1_q <= ctrl_one_q[C1_LEVEL1];
      end
      if (frc2) begin
        out2_q <= i_pwdata[C1_LEVEL2];
      end else if (m2 && !pwm_on) begin
        out2_q <= ctrl_one_q[C1_LEVEL2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and shared interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_compare_out_one  <= 1'b0;
      o_compare_out_two  <= 1'b0;
      o_compare_one_oe_n <= 1'b1;
      o_compare_two_oe_n <= 1'b1;
      o_timer_irq        <= 1'b0;
    end else begin
      o_compare_out_one  <= out1_q;
      o_compare_out_two  <= out2_q;
      o_compare_one_oe_n <= ~(ctrl_two_q[C2_PIN1_EN] & ~freeze_q);
      o_compare_two_oe_n <= ~(ctrl_two_q[C2_PIN2_EN] & ~freeze_q);
      o_timer_irq <= (ctrl_one_q[C1_CAP_IE] & (cap1_f_q | cap2_f_q))
                   | (ctrl_one_q[C1_CMP_IE] & (cmp1_f_q | cmp2_f_q))
                   | (ctrl_one_q[C1_OVF_IE] & ovf_f_q);
    end
  end

  // ----------------------------------------------------------------
  // Read mux over all registers
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL_ONE: rd_d[7:0] = ctrl_one_q;
      IDX_CTRL_TWO: rd_d[7:0] = ctrl_two_q;
      IDX_FLAGS:    rd_d[7:0] = {flags, freeze_q, 2'h0};
      IDX_CAP1_HI:  rd_d[7:0] = cap1_q[15:8];
      IDX_CAP1_LO:  rd_d[7:0] = cap1_q[7:0];
      IDX_CMP1_HI:  rd_d[7:0] = cmp1_q[15:8];
      IDX_CMP1_LO:  rd_d[7:0] = cmp1_q[7:0];
      IDX_CMP2_HI:  rd_d[7:0] = cmp2_q[15:8];
      IDX_CMP2_LO:  rd_d[7:0] = cmp2_q[7:0];
      IDX_CNT_HI,
      IDX_ACNT_HI:  rd_d[7:0] = cnt_q[15:8];
      IDX_CNT_LO,
      IDX_ACNT_LO:  rd_d[7:0] = cnt_q[7:0];
      IDX_CAP2_HI:  rd_d[7:0] = cap2_q[15:8];
      IDX_CAP2_LO:  rd_d[7:0] = cap2_q[7:0];
      default:      rd_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      o_prdata  <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  irq_source_a: assert property (
    ##1 o_timer_irq == $past((ctrl_one_q[C1_CAP_IE] & (cap1_f_q | cap2_f_q))
      | (ctrl_one_q[C1_CMP_IE] & (cmp1_f_q | cmp2_f_q)) | (ctrl_one_q[C1_OVF_IE] & ovf_f_q)))
    else $error("interrupt does not follow enabled flags");
  irq_mask_a: assert property (
    (ctrl_one_q[7:5] == 3'h0) |=> !o_timer_irq)
    else $error("interrupt raised with all enables clear");
  freeze_hold_a: assert property (
    (freeze_q && !cnt_wr && !(spm_on && cap1)) |=> $stable(cnt_q))
    else $error("counter moved while frozen");
  pwm_reload_a: assert property (
    (pwm_on && m2 && !cnt_wr) |=> (cnt_q == CNT_RST) && cap1_f_q)
    else $error("period end did not reload counter");
  force_one_a: assert property (
    frc1 |=> ##1 (o_compare_out_one == $past(i_pwdata[C1_LEVEL1], 2)))
    else $error("force one did not reach pin");
  match_two_a: assert property (
    (m2 && !pwm_on && !frc2) |=> out2_q == ctrl_one_q[C1_LEVEL2] || $past(wr))
    else $error("match two level wrong");
  ext_stop_a: assert property (
    (!EXT_PIN && clk_sel == CLK_EXT && !cnt_wr && !cap1 && !m2) |=> $stable(cnt_q))
    else $error("counter ran without external pin");
  apb_wait_a: assert property (
    (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
    else $error("ready not one cycle after access start");
  ctrl_two_rb_a: assert property (
    hit_idx(IDX_CTRL_TWO, wr) |=> ctrl_two_q == $past(i_pwdata[7:0]))
    else $error("control two write lost");
  pin_gate_a: assert property (
    freeze_q |=> o_compare_one_oe_n && o_compare_two_oe_n)
    else $error("pins driven while frozen");

  cov_pwm_c: cover property (pwm_on && m2);
  cov_spm_c: cover property (spm_on && cap1 ##[1:300] m1);
  cov_ovf_c: cover property (tick && cnt_q == CNT_TOP);
  cov_irq_c: cover property ($rose(o_timer_irq));
endmodule : t16_ctrl_regs

// ==== tb/t16_pins_model.sv ====
// Pin-side partner model: capture and external clock pins
`timescale 1ns/10ps
module t16_pins_model (
  // Clock and command
  input  wire logic i_clk_sys,
  input  wire logic i_cap_lvl,
  // Pins toward the timer
  output logic      o_cap_one,
  output logic      o_cap_two,
  output logic      o_ext_clk
);
  // Capture one follows the commanded level one edge later
  always_ff @(posedge i_clk_sys) begin
    o_cap_one <= i_cap_lvl;
  end
  // Capture two idles high, external clock stands still
  assign o_cap_two = 1'b1;
  assign o_ext_clk = 1'b0;
endmodule : t16_pins_model

// ==== tb/test_t16_ctrl_regs.sv ====
// Self-checking bench for the timer control block
`timescale 1ns/10ps
module test_t16_ctrl_regs;
  import t16_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, cap_lvl = 1'b0, cap1, cap2, ext;
  logic        out1, oe1_n, out2, oe2_n, irq;
  logic [7:0]  rd;
  logic        err;
  int          mismatches = 0, check_count = 0;
  always #5 clk = ~clk;
  t16_pins_model pins (.i_clk_sys(clk), .i_cap_lvl(cap_lvl), .o_cap_one(cap1),
    .o_cap_two(cap2), .o_ext_clk(ext));
  t16_ctrl_regs dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_capture_in_one(cap1),
    .i_capture_in_two(cap2), .i_ext_count_clock(ext), .o_compare_out_one(out1),
    .o_compare_one_oe_n(oe1_n), .o_compare_out_two(out2), .o_compare_two_oe_n(oe2_n),
    .o_timer_irq(irq));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin mismatches++; report_and_stop(); end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task automatic wait_irq(input logic exp);
    int n;
    for (n = 0; n < 60 && irq !== exp; n++) @(posedge clk);
    chk({7'h0, irq}, {7'h0, exp});
  endtask : wait_irq
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, IDX_CTRL_TWO, 8'h00); chk(rd, CTRL_RST);
    apb(1'b1, IDX_CTRL_TWO, 8'hFF); apb(1'b0, IDX_CTRL_TWO, 8'h00); chk(rd, 8'hFF);
    apb(1'b1, IDX_CTRL_TWO, 8'h00);
    apb(1'b0, 4'h0, 8'h00); chk({7'h0, err}, 8'h01);
    $display("test regs done");
  endtask : t_regs
  task automatic t_force;
    apb(1'b1, IDX_CTRL_TWO, 8'hC0);
    apb(1'b1, IDX_CTRL_ONE, 8'h1D);
    repeat (3) @(posedge clk);
    chk({4'h0, out1, oe1_n, out2, oe2_n}, 8'h0A);
    apb(1'b1, IDX_FLAGS, 8'h04);
    repeat (3) @(posedge clk);
    chk({6'h0, oe1_n, oe2_n}, 8'h03);
    apb(1'b1, IDX_FLAGS, 8'h00);
    $display("test force done");
  endtask : t_force
  task automatic t_irq;
    apb(1'b1, IDX_CTRL_ONE, 8'h82);
    cap_lvl <= 1'b1;
    wait_irq(1'b1);
    apb(1'b0, IDX_FLAGS, 8'h00); chk(rd & 8'h80, 8'h80);
    apb(1'b1, IDX_CTRL_ONE, 8'h00); wait_irq(1'b0);
    apb(1'b1, IDX_CTRL_ONE, 8'h20); wait_irq(1'b1);
    $display("test irq done");
  endtask : t_irq
  task automatic t_match;
    apb(1'b1, IDX_CTRL_ONE, 8'h00);
    apb(1'b1, IDX_CMP1_HI, 8'hFF);
    apb(1'b1, IDX_CMP1_LO, 8'hFE);
    apb(1'b1, IDX_CNT_LO, 8'h00);
    repeat (20) @(posedge clk);
    chk({7'h0, out1}, 8'h00);
    chk({7'h0, out2}, 8'h01);
    apb(1'b0, IDX_FLAGS, 8'h00); chk(rd & 8'h40, 8'h40);
    $display("test match done");
  endtask : t_match
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_force();
    t_irq();
    t_match();
    report_and_stop();
  end
endmodule : test_t16_ctrl_regs
